/* File: include/clock_monitor_pkg.sv */
// constants, field layouts and lookup functions for the clock tree and fault monitor
// assumes a single 125 MHz clock-tree input that keeps running while monitored clocks stop
package clock_monitor_pkg;

  // clock-tree input period
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned CYCLES_PER_US_DEFAULT = NS_PER_US / CLK_PERIOD_NS;

  // register addresses of the byte-wide register port
  localparam logic [7:0] ADDR_SELECT_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUTS = 8'h01;
  localparam logic [7:0] ADDR_MUTE_RAMP = 8'h02;
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h04;

  // field positions in clock_monitor_select_enable
  localparam int unsigned POS_A_SOURCE = 4;
  localparam int unsigned POS_B_SOURCE = 2;
  localparam int unsigned POS_A_ENABLE = 1;
  localparam int unsigned POS_B_ENABLE = 0;
  // field positions in clock_monitor_timeouts and clock_fault_mute_ramp
  localparam int unsigned POS_A_TIMEOUT = 3;
  localparam int unsigned POS_B_TIMEOUT = 0;
  localparam int unsigned POS_MUTE_RATE = 6;
  // flag bit positions in the sticky flags and mask registers
  localparam int unsigned POS_FLAG_A = 0;
  localparam int unsigned POS_FLAG_B = 1;

  // reset values
  localparam logic [7:0] RST_SELECT_ENABLE = 8'h03;
  localparam logic [7:0] RST_TIMEOUTS = 8'h3f;
  localparam logic [7:0] RST_MUTE_RAMP = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK = 8'h00;

  // monitor b source codes
  localparam logic [1:0] SRC_B_PLAYBACK_MOD = 2'h0;
  localparam logic [1:0] SRC_B_SENSE_MOD = 2'h1;
  localparam logic [1:0] SRC_B_PLL = 2'h2;

  // mute ramp base step and depth of the full mute
  localparam int unsigned MUTE_STEP_BASE_US = 15;
  localparam logic [7:0] MUTE_DEPTH_DB = 8'h64;

  // width of the idle and ramp counters
  localparam int unsigned IDLE_W = 28;
  localparam int unsigned STEP_W = 24;

  // timeout of a 3-bit code, in microseconds
  function automatic int unsigned timeout_us(input logic [2:0] code);
    case (code)
      3'h0: timeout_us = 11000;
      3'h1: timeout_us = 22000;
      3'h2: timeout_us = 44000;
      3'h3: timeout_us = 87000;
      3'h4: timeout_us = 174000;
      3'h5: timeout_us = 350000;
      3'h6: timeout_us = 700000;
      default: timeout_us = 1200000;
    endcase
  endfunction

  // mute ramp step of a 2-bit rate code, in microseconds per dB
  function automatic int unsigned ramp_us(input logic [1:0] code);
    ramp_us = MUTE_STEP_BASE_US << code;
  endfunction

endpackage

/* File: include/monitor_if.sv */
// bundle between the fault monitor top and one clock-loss detector
// assumes the top drives enable, sample and limit and the detector answers with fault
`timescale 1ns/10ps
interface monitor_if;
  import clock_monitor_pkg::*;
  logic enable;
  logic sample;
  logic [IDLE_W-1:0] limit;
  logic fault;
  modport ctrl (output enable, output sample, output limit, input fault);
  modport det (input enable, input sample, input limit, output fault);
endinterface

/* File: src/clock_loss_detector.sv */
// one clock-loss detector: counts reference cycles since the last edge of its sample
// assumes sample is synchronous to clk_in and limit is at least one cycle
`timescale 1ns/10ps
module clock_loss_detector
  import clock_monitor_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  monitor_if.det mon
);

  logic prev_reg;
  logic [IDLE_W-1:0] idle_reg;
  logic fault_reg;
  logic activity;

  // either edge of the monitored clock counts as activity
  assign activity = mon.sample != prev_reg;
  assign mon.fault = fault_reg;

  // previous sample for edge detection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= mon.sample;
    end
  end

  // idle counter runs on the free reference so a dead clock still times out; see RULE16
  always_ff @(posedge clk_in) begin
    if (rst_in || !mon.enable || activity) begin
      idle_reg <= '0;
    end else if (idle_reg < mon.limit) begin
      idle_reg <= idle_reg + IDLE_W'(1);
    end
  end

  // fault raised after limit idle cycles, dropped on the first returning edge; see RULE11
  always_ff @(posedge clk_in) begin
    if (rst_in || !mon.enable || activity) begin
      fault_reg <= 1'b0;
    end else if (idle_reg >= mon.limit - IDLE_W'(1)) begin
      fault_reg <= 1'b1;
    end
  end

  a_timeout_exact: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE11
    $rose(fault_reg) |-> $past(idle_reg) == $past(mon.limit) - IDLE_W'(1))
    else $error("fault raised at wrong idle count");

  a_edge_clears: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE15
    (mon.enable && activity) |=> !fault_reg && idle_reg == '0)
    else $error("activity did not clear the detector");

  a_disabled_quiet: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE6
    !mon.enable |=> !fault_reg)
    else $error("disabled detector raised a fault");

endmodule

/* File: src/clock_tree_error_monitor.sv */
// clock tree dividers, two clock-loss detectors, fault mute ramp and sticky fault flags
// assumes mclk_in is the clock-tree input and free-running; register port sits behind
// an i2c slave engine outside this block, one byte per access
//
// How it works
// RULE1: host programs the pll output to 1024 times the sample rate.
// RULE2: half-rate node is input over 2, both modulator clocks input over 16.
// RULE3: two independent loss detectors; either one soft-mutes playback.
// RULE4: monitor a watches serial audio clock (0, default) or density clock (1).
// RULE5: monitor b watches playback mod, sense mod or pll clock; 11 reserved.
// RULE6: bit 1 enables monitor a, bit 0 monitor b; both enabled at reset.
// RULE7: host enables or disables both detectors together.
// RULE8: host should normally keep both detectors disabled.
// RULE9: host turns off idle-channel detection while detectors are enabled.
// RULE10: host writes page 0x32, four zeros from 0x6c, then page 0.
// RULE11: a detector faults when its clock is idle longer than its timeout.
// RULE12: 3-bit timeout code selects 11 ms up to 1.2 s, default 1.2 s.
// RULE13: fault ramps playback down at 15, 30, 60 or 120 us per dB.
// RULE14: each fault sets a sticky flag; interrupt pin only when masked in.
// RULE15: on clock return playback ramps back up without a pop.
// RULE16: timeouts are measured on a reference that runs when monitored clocks stop.
`timescale 1ns/10ps
module clock_tree_error_monitor
  import clock_monitor_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = CYCLES_PER_US_DEFAULT
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic serial_audio_clock_in,
  input wire logic density_mod_clock_in,
  input wire logic pll_clock_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic half_rate_node_out,
  output logic playback_modulator_clock_out,
  output logic sense_modulator_clock_out,
  output logic [7:0] mute_atten_db_out,
  output logic playback_mute_out,
  output logic irq_out
);

  typedef enum logic [1:0] {ST_RUN, ST_DOWN, ST_MUTED, ST_UP} mute_state_t;

  logic [3:0] div_cnt_reg;
  logic [7:0] select_enable_reg;
  logic [7:0] timeouts_reg;
  logic [7:0] mute_ramp_reg;
  logic [7:0] fault_mask_reg;
  logic [1:0] fault_flags_reg;
  logic [1:0] fault_prev_reg;
  logic [STEP_W-1:0] step_cnt_reg;
  logic [STEP_W-1:0] step_cycles;
  logic step_tick;
  mute_state_t state_reg;
  logic [1:0] fault_now;
  logic [1:0] fault_rise;
  logic any_fault;
  logic flags_read;
  logic [1:0] b_source;
  logic b_sample;

  monitor_if mon_a ();
  monitor_if mon_b ();

  // free-running divider; bit 0 is the half-rate node, bit 3 the modulator rate
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      div_cnt_reg <= 4'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1; // see RULE2
    end
  end

  // outputs taken straight from the divider flops; both modulator clocks share one stage
  assign half_rate_node_out = div_cnt_reg[0];
  assign playback_modulator_clock_out = div_cnt_reg[3];
  assign sense_modulator_clock_out = div_cnt_reg[3];

  // register writes; bits without a field stay zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      select_enable_reg <= RST_SELECT_ENABLE;
      timeouts_reg <= RST_TIMEOUTS;
      mute_ramp_reg <= RST_MUTE_RAMP;
      fault_mask_reg <= RST_FAULT_MASK;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_SELECT_ENABLE: select_enable_reg <= reg_wdata_in & 8'h1f; // see RULE6
        ADDR_TIMEOUTS: timeouts_reg <= reg_wdata_in & 8'h3f;
        ADDR_MUTE_RAMP: mute_ramp_reg <= reg_wdata_in & 8'hc0;
        ADDR_FAULT_MASK: fault_mask_reg <= reg_wdata_in & 8'h03;
        default: ;
      endcase
    end
  end

  // monitor a: serial audio clock or density clock; see RULE4
  assign mon_a.sample = select_enable_reg[POS_A_SOURCE] ? density_mod_clock_in
                                                        : serial_audio_clock_in;
  assign mon_a.enable = select_enable_reg[POS_A_ENABLE];
  assign mon_a.limit = IDLE_W'(timeout_us(timeouts_reg[POS_A_TIMEOUT +: 3]) * CYCLES_PER_US);

  // monitor b: internal clocks; the reserved code switches the detector off
  assign b_source = select_enable_reg[POS_B_SOURCE +: 2];
  always_comb begin
    case (b_source) // see RULE5
      SRC_B_PLAYBACK_MOD: b_sample = div_cnt_reg[3];
      SRC_B_SENSE_MOD: b_sample = div_cnt_reg[3];
      SRC_B_PLL: b_sample = pll_clock_in;
      default: b_sample = 1'b0;
    endcase
  end
  assign mon_b.sample = b_sample;
  assign mon_b.enable = select_enable_reg[POS_B_ENABLE] && (b_source != 2'h3);
  // see RULE12
  assign mon_b.limit = IDLE_W'(timeout_us(timeouts_reg[POS_B_TIMEOUT +: 3]) * CYCLES_PER_US);

  // two independent detectors on the same free reference; see RULE3
  clock_loss_detector det_a (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .mon(mon_a)
  );

  clock_loss_detector det_b (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .mon(mon_b)
  );

  assign fault_now = {mon_b.fault, mon_a.fault};
  assign any_fault = |fault_now;
  assign fault_rise = fault_now & ~fault_prev_reg;
  assign flags_read = reg_rd_in && (reg_addr_in == ADDR_FAULT_FLAGS);

  // edge memory so each fault sets its flag once
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fault_prev_reg <= 2'h0;
    end else begin
      fault_prev_reg <= fault_now;
    end
  end

  // sticky flags clear on read; a fault in the read cycle wins over the clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fault_flags_reg <= 2'h0;
    end else begin
      fault_flags_reg <= (flags_read ? 2'h0 : fault_flags_reg) | fault_rise; // see RULE14
    end
  end

  // interrupt pin only for flags whose mask bit is set
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(fault_flags_reg & fault_mask_reg[1:0]); // see RULE14
    end
  end

  // register reads, registered; unmapped addresses read zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_SELECT_ENABLE: reg_rdata_out <= select_enable_reg;
        ADDR_TIMEOUTS: reg_rdata_out <= timeouts_reg;
        ADDR_MUTE_RAMP: reg_rdata_out <= mute_ramp_reg;
        ADDR_FAULT_FLAGS: reg_rdata_out <= {6'h00, fault_flags_reg};
        ADDR_FAULT_MASK: reg_rdata_out <= fault_mask_reg;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ramp step timer: one dB step per selected interval, only while ramping
  assign step_cycles = STEP_W'(ramp_us(mute_ramp_reg[POS_MUTE_RATE +: 2]) * CYCLES_PER_US);
  assign step_tick = step_cnt_reg >= step_cycles - STEP_W'(1);

  always_ff @(posedge mclk_in) begin
    if (rst_in || state_reg == ST_RUN || state_reg == ST_MUTED || step_tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + STEP_W'(1); // see RULE13
    end
  end

  // mute sequencer; ramping in dB steps both ways keeps the gain change free of clicks
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= ST_RUN;
      mute_atten_db_out <= 8'h00;
      playback_mute_out <= 1'b0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (any_fault) begin
            state_reg <= ST_DOWN; // see RULE3
            playback_mute_out <= 1'b1;
          end
        end
        ST_DOWN: begin
          if (!any_fault) begin
            state_reg <= ST_UP;
          end else if (mute_atten_db_out >= MUTE_DEPTH_DB) begin
            state_reg <= ST_MUTED; // re-entry from the up ramp at full depth must not overshoot
          end else if (step_tick) begin
            mute_atten_db_out <= mute_atten_db_out + 8'h01; // see RULE13
            if (mute_atten_db_out == MUTE_DEPTH_DB - 8'h01) begin
              state_reg <= ST_MUTED;
            end
          end
        end
        ST_MUTED: begin
          if (!any_fault) begin
            state_reg <= ST_UP; // see RULE15
          end
        end
        ST_UP: begin
          if (any_fault) begin
            state_reg <= ST_DOWN;
          end else if (mute_atten_db_out == 8'h00) begin
            state_reg <= ST_RUN;
            playback_mute_out <= 1'b0;
          end else if (step_tick) begin
            mute_atten_db_out <= mute_atten_db_out - 8'h01; // see RULE15
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  a_half_rate_toggle: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE2
    !$past(rst_in) |-> half_rate_node_out != $past(half_rate_node_out))
    else $error("half-rate node did not toggle");

  a_mod_high_eight: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE2
    $rose(playback_modulator_clock_out) |-> playback_modulator_clock_out[*8] ##1
      !playback_modulator_clock_out)
    else $error("modulator clock high phase not eight cycles");

  a_fault_mutes: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE3
    (state_reg == ST_RUN && any_fault) |=> state_reg == ST_DOWN && playback_mute_out)
    else $error("fault did not start the mute ramp");

  a_source_a_select: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE4
    (select_enable_reg[POS_A_SOURCE] == 1'b0) |-> mon_a.sample == serial_audio_clock_in)
    else $error("monitor a not on serial audio clock");

  a_reserved_off: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE5
    (b_source == 2'h3) [*2] |-> !mon_b.fault)
    else $error("reserved source raised a fault");

  a_flag_sticky: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE14
    $rose(mon_a.fault) |=> fault_flags_reg[POS_FLAG_A] ##1 fault_flags_reg[POS_FLAG_A] || 
      $past(flags_read))
    else $error("fault flag not set or not held");

  a_irq_gated: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE14
    ((fault_flags_reg & fault_mask_reg[1:0]) == 2'h0) |=> !irq_out)
    else $error("interrupt without a masked-in flag");

  a_ramp_step: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE13
    (mute_atten_db_out != $past(mute_atten_db_out)) |-> $past(step_tick))
    else $error("attenuation moved without a step tick");

  a_unmute_return: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE15
    (state_reg == ST_MUTED && !any_fault) |=> state_reg == ST_UP ##1
      mute_atten_db_out <= MUTE_DEPTH_DB)
    else $error("clock return did not start the un-mute");

  // mute sequencer bounds and fault to flag to pin path
  a_atten_bounded: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE13
    mute_atten_db_out <= MUTE_DEPTH_DB)
    else $error("attenuation beyond full mute depth");

  a_depth_reached: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE13
    (state_reg == ST_DOWN && any_fault && step_tick && mute_atten_db_out == MUTE_DEPTH_DB - 8'h01)
      |=> state_reg == ST_MUTED && mute_atten_db_out == MUTE_DEPTH_DB)
    else $error("ramp did not stop at full depth");

  a_mute_held: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE3
    (state_reg != ST_RUN) |-> playback_mute_out)
    else $error("mute dropped before the un-mute finished");

  a_run_unmuted: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE15
    (state_reg == ST_RUN) |-> !playback_mute_out && mute_atten_db_out == 8'h00)
    else $error("normal run with mute or attenuation left");

  a_flag_b_set: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE14
    $rose(mon_b.fault) |=> fault_flags_reg[POS_FLAG_B])
    else $error("monitor b fault did not set its flag");

  a_irq_follows: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE14
    ((fault_flags_reg & fault_mask_reg[1:0]) != 2'h0) |=> irq_out)
    else $error("masked-in flag did not raise the interrupt");

endmodule

/* File: verif/audio_clock_sources.sv */
// behavioural model of the three monitored clocks, each with its own run control
// assumes run inputs change just after mclk edges; a stopped clock holds its last level
`timescale 1ns/10ps
module audio_clock_sources #(
  parameter int unsigned HALF = 4
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic run_serial_in,
  input wire logic run_density_in,
  input wire logic run_pll_in,
  output logic serial_audio_clock_out,
  output logic density_mod_clock_out,
  output logic pll_clock_out
);
  logic [7:0] phase_reg;
  logic tick;

  // shared phase counter, kept well below mclk/2 so the sampler sees every edge
  always_ff @(posedge mclk_in) begin
    if (rst_in || tick) begin
      phase_reg <= 8'h00;
    end else begin
      phase_reg <= phase_reg + 8'h01;
    end
  end
  assign tick = (phase_reg == 8'(HALF - 1));

  // each source toggles on the tick only while it runs, so a stop freezes the line
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      serial_audio_clock_out <= 1'b0;
      density_mod_clock_out <= 1'b0;
      pll_clock_out <= 1'b0;
    end else if (tick) begin
      serial_audio_clock_out <= serial_audio_clock_out ^ run_serial_in;
      density_mod_clock_out <= density_mod_clock_out ^ run_density_in;
      pll_clock_out <= pll_clock_out ^ run_pll_in; // fixed ratio to mclk
    end
  end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the clock tree and fault monitor
// assumes CYCLES_PER_US = 1, so timeout code 0 lasts 11000 cycles and rate code 0 is 15
`timescale 1ns/10ps
module tb;
  import clock_monitor_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_t;
  localparam int LIM0 = 11000;
  logic mclk_in, rst_in, reg_wr_in, reg_rd_in, run_s, run_d, run_p, sclk, dclk, pclk;
  logic half, pmod, smod, mute, irq, h, p;
  logic [7:0] reg_addr_in, reg_wdata_in, rdata, atten, prev, d;
  int err_count, num_checks, n, nh, np, ns;
  // register rows: reset reads first, then write and read back, odd places last
  row_t rows [14] = '{
    '{1'b0, 8'h00, 8'h00, RST_SELECT_ENABLE}, '{1'b0, 8'h01, 8'h00, RST_TIMEOUTS},
    '{1'b0, 8'h02, 8'h00, RST_MUTE_RAMP}, '{1'b0, 8'h03, 8'h00, 8'h00},
    '{1'b0, 8'h04, 8'h00, RST_FAULT_MASK}, '{1'b1, 8'h00, 8'hfd, 8'h1d},
    '{1'b1, 8'h00, 8'h0a, 8'h0a}, '{1'b1, 8'h01, 8'hff, 8'h3f},
    '{1'b1, 8'h01, 8'h12, 8'h12}, '{1'b1, 8'h02, 8'hff, 8'hc0},
    '{1'b1, 8'h02, 8'h40, 8'h40}, '{1'b1, 8'h04, 8'hff, 8'h03},
    '{1'b1, 8'h03, 8'hff, 8'h00}, '{1'b1, 8'h07, 8'hff, 8'h00}};

  clock_tree_error_monitor #(.CYCLES_PER_US(1)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .serial_audio_clock_in(sclk), .density_mod_clock_in(dclk), .pll_clock_in(pclk),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .half_rate_node_out(half),
    .playback_modulator_clock_out(pmod), .sense_modulator_clock_out(smod),
    .mute_atten_db_out(atten), .playback_mute_out(mute), .irq_out(irq));
  audio_clock_sources i_src (.mclk_in(mclk_in), .rst_in(rst_in), .run_serial_in(run_s),
    .run_density_in(run_d), .run_pll_in(run_p), .serial_audio_clock_out(sclk),
    .density_mod_clock_out(dclk), .pll_clock_out(pclk));

  // 125 mhz clock-tree input
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes last one cycle; the next access waits for a fresh edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 v = rdata;
  endtask

  // bounded wait on mute (sel 0) or attenuation (sel 1), counting cycles
  task automatic wait_for(input logic sel, input logic [7:0] v, input int bound,
                          output int cnt);
    cnt = 0;
    while ((sel ? atten : {7'h00, mute}) !== v) begin
      @(posedge mclk_in);
      #1 cnt++;
      if (cnt > bound) begin
        chk(sel ? atten : {7'h00, mute}, v);
        results();
      end
    end
  endtask

  initial begin
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    run_s = 1'b1;
    run_d = 1'b1;
    run_p = 1'b1;
    err_count = 0;
    num_checks = 0;
    ns = 0;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1 chk({mute, irq, 6'h00}, 8'h00);
    chk(atten, 8'h00);
    // divider nodes over 64 cycles
    h = half;
    p = pmod;
    nh = 0;
    np = 0;
    repeat (64) begin
      @(posedge mclk_in);
      #1 nh += int'(half !== h);
      np += int'(pmod !== p);
      ns += int'(smod !== pmod);
      h = half;
      p = pmod;
    end
    chk(8'(nh), 8'h40);
    chk(8'(np), 8'h08);
    chk(8'(ns), 8'h00);
    $display("test dividers done");
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].wdata);
      end
      rd(rows[i].addr, d);
      chk(d, rows[i].exp);
    end
    $display("test registers done");
    // serial clock stops with monitor a on it, shortest timeout, fastest ramp
    wr(ADDR_SELECT_ENABLE, 8'h03);
    // host duty: idle-channel detection sits outside this block, so its writes land unmapped
    for (int k = 0; k < 4; k++) begin
      wr(8'h6c + 8'(k), 8'h00);
    end
    rd(8'h6c, d);
    chk(d, 8'h00);
    wr(ADDR_TIMEOUTS, 8'h00);
    wr(ADDR_MUTE_RAMP, 8'h00);
    wr(ADDR_FAULT_MASK, 8'h03);
    @(posedge mclk_in);
    run_s <= 1'b0;
    wait_for(1'b0, 8'h01, LIM0 + 20, n);
    chk(8'(n > LIM0 - 8 && n < LIM0 + 8), 8'h01);
    repeat (2) @(posedge mclk_in);
    #1 chk({7'h00, irq}, 8'h01);
    wait_for(1'b1, MUTE_DEPTH_DB, 1600, n);
    chk(8'(n > 1488 && n < 1508), 8'h01);
    repeat (50) @(posedge mclk_in);
    #1 chk({mute, atten[6:0]}, 8'he4);
    @(posedge mclk_in);
    run_s <= 1'b1;
    prev = atten;
    ns = 0;
    n = 0;
    // un-mute must walk down one dB at a time, never jumping or rising
    while (mute !== 1'b0 && n < 2000) begin
      @(posedge mclk_in);
      #1 n++;
      ns += int'((prev - atten) > 8'h01);
      prev = atten;
    end
    chk({mute, atten[6:0]}, 8'h00);
    chk(8'(ns), 8'h00);
    rd(ADDR_FAULT_FLAGS, d);
    chk(d, 8'h01);
    rd(ADDR_FAULT_FLAGS, d);
    chk(d, 8'h00);
    @(posedge mclk_in);
    #1 chk({7'h00, irq}, 8'h00);
    $display("test monitor a fault done");
    // a on density clock ignores the serial stop, b on the pll clock faults unmasked
    wr(ADDR_SELECT_ENABLE, 8'h1b);
    wr(ADDR_MUTE_RAMP, 8'hc0);
    wr(ADDR_FAULT_MASK, 8'h01);
    @(posedge mclk_in);
    run_s <= 1'b0;
    run_p <= 1'b0;
    wait_for(1'b0, 8'h01, LIM0 + 20, n);
    wait_for(1'b1, 8'h01, 200, n);
    wait_for(1'b1, 8'h02, 200, n);
    chk(8'(n > 116 && n < 124), 8'h01);
    chk({7'h00, irq}, 8'h00);
    // the two middle rates, switched while the ramp is running
    wr(ADDR_MUTE_RAMP, 8'h80);
    wait_for(1'b1, 8'h03, 200, n);
    wait_for(1'b1, 8'h04, 200, n);
    chk(8'(n > 56 && n < 64), 8'h01);
    wr(ADDR_MUTE_RAMP, 8'h40);
    wait_for(1'b1, 8'h05, 200, n);
    wait_for(1'b1, 8'h06, 200, n);
    chk(8'(n > 26 && n < 34), 8'h01);
    @(posedge mclk_in);
    run_s <= 1'b1;
    run_p <= 1'b1;
    wait_for(1'b0, 8'h00, 600, n);
    rd(ADDR_FAULT_FLAGS, d);
    chk(d, 8'h02);
    $display("test monitor b fault done");
    // both detectors off, every clock stopped: no mute, no flag
    wr(ADDR_SELECT_ENABLE, 8'h00);
    @(posedge mclk_in);
    run_s <= 1'b0;
    run_d <= 1'b0;
    run_p <= 1'b0;
    ns = 0;
    repeat (LIM0 + 100) begin
      @(posedge mclk_in);
      #1 ns += int'(mute !== 1'b0);
    end
    chk(8'(ns), 8'h00);
    rd(ADDR_FAULT_FLAGS, d);
    chk(d, 8'h00);
    $display("test detectors off done");
    // reset in mid-run: changed registers fall back to their reset values
    wr(ADDR_FAULT_MASK, 8'h03);
    wr(ADDR_TIMEOUTS, 8'h09);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1 chk({mute, irq, 6'h00}, 8'h00);
    chk(atten, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(rows[i].addr, d);
      chk(d, rows[i].exp);
    end
    $display("test reset in mid-run done");
    results();
  end
endmodule
